// ===== pid_process_controller_defines.svh
`ifndef PID_PROCESS_CONTROLLER_DEFINES_SVH
`define PID_PROCESS_CONTROLLER_DEFINES_SVH

// ----------------------------------------
// source codes
// ----------------------------------------
`define SRC_KEYPAD        3'h0
`define SRC_AIN_ONE       3'h1
`define SRC_AIN_TWO       3'h2
`define SRC_STORED        3'h4
`define SRC_MAIN_CMD      3'h6

// ----------------------------------------
// control-mode field positions
// ----------------------------------------
`define MODE_ENABLE_BIT   0
`define MODE_INVERT_BIT   1
`define MODE_DFB_BIT      2
`define MODE_ADD_BIT      3

// ----------------------------------------
// scaling: percent values in tenths, 1000 = 100.0 %
// ----------------------------------------
`define PCT_FULL          16'h03E8
`define AIN_FULL          16'h0FFF
`define GAIN_ONE          16'h0064
`define OGAIN_ONE         16'h000A
`define TIME_TENTHS       16'h000A
`define FB_MAX_LIMIT      16'h03E8
`define APP_PUMP          2'h1
`define APP_HVAC          2'h2
`define SAT_POS           32'h0000_7FFF
`define SAT_NEG           32'hFFFF_8000

// ----------------------------------------
// sample tick: 1 ms at 100 MHz
// ----------------------------------------
`define TICK_TIME_NS      1000000
`define CLK_PERIOD_NS     10
`define TICK_CYCLES       (`TICK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== pid_process_controller_pkg.sv
package pid_process_controller_pkg;

	typedef struct packed {
		logic [2:0]  targetSrc;
		logic [1:0]  feedbackSrc;
		logic [3:0]  mode;
		logic [15:0] storedTarget;
		logic [15:0] propGain;
		logic [15:0] integTime;
		logic [15:0] diffTime;
		logic        allowReverse;
		logic [15:0] rampTime;
		logic [15:0] integLimit;
		logic [15:0] outLimit;
		logic signed [15:0] bias;
		logic [15:0] outGain;
		logic [15:0] fbMax;
		logic [1:0]  decimals;
		logic [1:0]  appFunction;
		logic        ledModeZero;
	} pid_cfg_s;

	typedef enum logic [1:0] {
		IDLE,
		RUN
	} pid_state_e;

endpackage

// ===== pid_process_controller.sv
`timescale 1ns/1ps
`include "pid_process_controller_defines.svh"

module pid_process_controller
	import pid_process_controller_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)
(
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               clkEn,
	input  wire pid_cfg_s           cfg,
	input  wire logic        [15:0] analogInputOne,
	input  wire logic        [15:0] analogInputTwo,
	input  wire logic        [15:0] mainFreqCmd,
	input  wire logic        [15:0] pumpTarget,
	input  wire logic               driveRunning,
	output logic signed      [15:0] freqRef_reg,
	output logic             [15:0] targetDisplay_reg,
	output logic                    settingConflictAlarm_reg,
	output logic                    pidActive_reg
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > $signed(`SAT_POS))
			sat16 = 16'sh7FFF;
		else if (v < $signed(`SAT_NEG))
			sat16 = -16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	function automatic logic signed [15:0] clampMag(input logic signed [15:0] v,
	                                               input logic [15:0] lim);
		logic signed [16:0] l;
		l = {1'b0, lim};
		if (signed'({v[15], v}) > l)
			clampMag = l[15:0];
		else if (signed'({v[15], v}) < -l)
			clampMag = -l[15:0];
		else
			clampMag = v;
	endfunction

	function automatic logic [15:0] ainToPct(input logic [15:0] a);
		logic [31:0] p;
		p = {16'h0000, a} * {16'h0000, `PCT_FULL};
		ainToPct = 16'((p / {16'h0000, `AIN_FULL}));
	endfunction

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	logic        pumpAllowed;
	logic [15:0] rawTarget;
	logic [15:0] feedback;
	logic        sameSource;
	logic        displayBad;
	logic        configBad;

	assign pumpAllowed = (cfg.appFunction == `APP_PUMP) || (cfg.appFunction == `APP_HVAC);
	assign rawTarget   = (cfg.targetSrc == `SRC_AIN_ONE) ? ainToPct(analogInputOne) :
	                     (cfg.targetSrc == `SRC_AIN_TWO) ? ainToPct(analogInputTwo) :
	                     (cfg.targetSrc == `SRC_STORED)  ? ((cfg.storedTarget > `PCT_FULL) ?
	                                                        `PCT_FULL : cfg.storedTarget) :
	                     (cfg.targetSrc == `SRC_MAIN_CMD) ? mainFreqCmd :
	                     (cfg.targetSrc == `SRC_KEYPAD && pumpAllowed) ? pumpTarget :
	                     16'h0000;
	assign feedback    = (cfg.feedbackSrc == 2'h1) ? ainToPct(analogInputOne) :
	                     (cfg.feedbackSrc == 2'h2) ? ainToPct(analogInputTwo) : 16'h0000;
	assign sameSource  = (cfg.feedbackSrc != 2'h0) && (cfg.feedbackSrc != 2'h3) &&
	                     (cfg.targetSrc == {1'b0, cfg.feedbackSrc});
	assign displayBad  = cfg.ledModeZero &&
	                     !((cfg.fbMax < `FB_MAX_LIMIT) && (cfg.decimals == 2'h1));
	assign configBad   = sameSource || displayBad;

	// ----------------------------------------
	// tick and target ramp
	// ----------------------------------------
	logic [31:0] tickCnt_reg;
	logic        tick;
	logic [15:0] rampTarget_reg;
	logic [15:0] rampStep;
	logic        enabled;

	assign tick     = clkEn && (tickCnt_reg == 32'(TICK_CYCLES - 1));
	assign enabled  = cfg.mode[`MODE_ENABLE_BIT] && !configBad;
	// step per tick: full span over ramp time (tenths of s, 100 ticks each)
	assign rampStep = (cfg.rampTime == 16'h0000) ? `PCT_FULL :
	                  16'(({16'h0000, `PCT_FULL} + 32'({16'h0000, cfg.rampTime} * 32'd100) - 32'd1) /
	                      32'({16'h0000, cfg.rampTime} * 32'd100));

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			tickCnt_reg <= 32'h0000_0000;
		else if (clkEn)
			tickCnt_reg <= tick ? 32'h0000_0000 : tickCnt_reg + 32'h0000_0001;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rampTarget_reg <= 16'h0000;
		else if (tick)
		begin
			if (rawTarget > rampTarget_reg + rampStep || rampTarget_reg + rampStep < rampTarget_reg)
				rampTarget_reg <= rampTarget_reg + rampStep;
			else if (rawTarget + rampStep < rampTarget_reg)
				rampTarget_reg <= rampTarget_reg - rampStep;
			else
				rampTarget_reg <= rawTarget;
		end
	end

	// ----------------------------------------
	// controller terms
	// ----------------------------------------
	logic signed [15:0] err;
	logic signed [15:0] dSrc;
	logic signed [15:0] dPrev_reg;
	logic signed [15:0] integ_reg;
	logic signed [15:0] integNext;
	logic signed [15:0] pTerm;
	logic signed [15:0] dTerm;
	logic signed [15:0] pidSum;
	logic signed [15:0] pidPol;
	logic signed [15:0] pidLim;
	logic signed [15:0] withBias;
	logic signed [15:0] freqNext;
	pid_state_e         state_reg;

	assign err   = sat16(32'(signed'({16'h0000, rampTarget_reg})) - 32'(signed'({16'h0000, feedback})));
	assign pTerm = sat16(32'(err * signed'({1'b0, cfg.propGain})) / 32'sd100);
	// integral adds err*10 / (time in ticks); zero time disables the integral
	assign integNext = (cfg.integTime == 16'h0000) ? 16'sh0000 :
	                   clampMag(sat16(32'(integ_reg) + 32'(err * 32'sd10) /
	                                  32'(signed'({1'b0, cfg.integTime}) * 32'sd100)),
	                            cfg.integLimit);
	assign dSrc  = cfg.mode[`MODE_DFB_BIT] ? -signed'(feedback) : err;
	assign dTerm = sat16(32'(sat16(32'(dSrc) - 32'(dPrev_reg)) * signed'({1'b0, cfg.diffTime})));
	assign pidSum = sat16(32'(pTerm) + 32'(integ_reg) + 32'(dTerm));
	assign pidPol = cfg.mode[`MODE_INVERT_BIT] ? -pidSum : pidSum;
	assign pidLim = clampMag(pidPol, cfg.outLimit);
	assign withBias = sat16(32'(pidLim) + 32'(cfg.bias) * 32'(signed'({1'b0, cfg.outGain})) / 32'sd10);
	assign freqNext = (!cfg.allowReverse && withBias < 0) ? 16'sh0000 :
	                  (cfg.mode[`MODE_ADD_BIT] && driveRunning) ?
	                  sat16(32'(withBias) + 32'(signed'({1'b0, mainFreqCmd}))) : withBias;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= IDLE;
			integ_reg <= 16'sh0000;
			dPrev_reg <= 16'sh0000;
			freqRef_reg <= 16'sh0000;
		end
		else if (tick)
		begin
			case (state_reg)
				IDLE:
				begin
					integ_reg <= 16'sh0000;
					dPrev_reg <= dSrc;
					freqRef_reg <= 16'sh0000;
					if (enabled)
						state_reg <= RUN;
				end
				RUN:
				begin
					integ_reg <= integNext;
					dPrev_reg <= dSrc;
					freqRef_reg <= freqNext;
					if (!enabled)
						state_reg <= IDLE;
				end
				default:
					state_reg <= IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// status and display
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			settingConflictAlarm_reg <= 1'b0;
			targetDisplay_reg <= 16'h0000;
			pidActive_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			settingConflictAlarm_reg <= configBad;
			targetDisplay_reg <= 16'(({16'h0000, cfg.fbMax} * {16'h0000, rampTarget_reg}) /
			                         {16'h0000, `PCT_FULL});
			pidActive_reg <= (state_reg == RUN);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_alarm_same_src: assert property (@(posedge core_clk) disable iff (!rst_n)
		clkEn && sameSource |=> settingConflictAlarm_reg)
		else $error("same source did not raise alarm");

	chk_alarm_led_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		clkEn && cfg.ledModeZero && cfg.fbMax >= `FB_MAX_LIMIT |=> settingConflictAlarm_reg)
		else $error("display setting not flagged");

	chk_no_negative: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && !cfg.allowReverse |=> freqRef_reg >= 0)
		else $error("negative output without reversal");

	chk_disabled_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && state_reg == IDLE |=> freqRef_reg == 16'sh0000)
		else $error("output not zero while disabled");

	chk_integ_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick |=> (integ_reg <= $signed({1'b0, $past(cfg.integLimit)}) &&
		          integ_reg >= -$signed({1'b0, $past(cfg.integLimit)})))
		else $error("integral beyond limit");

	chk_out_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
		pidLim <= $signed({1'b0, cfg.outLimit}) && pidLim >= -$signed({1'b0, cfg.outLimit}))
		else $error("output beyond limit");

	chk_ramp_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tick |=> $stable(rampTarget_reg))
		else $error("ramp moved off tick");

	chk_enable_run: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && state_reg == IDLE && enabled |=> state_reg == RUN)
		else $error("enable did not start controller");

	chk_run_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && state_reg == RUN && !enabled |=> state_reg == IDLE)
		else $error("disable did not stop controller");

	chk_active_match: assert property (@(posedge core_clk) disable iff (!rst_n)
		clkEn |=> pidActive_reg == ($past(state_reg) == RUN))
		else $error("active flag does not follow state");

	chk_conflict_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && configBad |=> state_reg == IDLE)
		else $error("controller ran with bad setting");

	chk_alarm_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		clkEn && !configBad |=> !settingConflictAlarm_reg)
		else $error("alarm raised with good setting");

	chk_led_ok: assert property (@(posedge core_clk) disable iff (!rst_n)
		clkEn && !sameSource && !cfg.ledModeZero |=> !settingConflictAlarm_reg)
		else $error("display alarm without display mode");

	chk_integ_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && state_reg == RUN && cfg.integTime == 16'h0000 |=> integ_reg == 16'sh0000)
		else $error("integral moved with zero time");

	chk_idle_integ: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && state_reg == IDLE |=> integ_reg == 16'sh0000)
		else $error("integral kept while disabled");

	chk_ramp_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick && cfg.rampTime == 16'h0000 && rawTarget <= `PCT_FULL |=> rampTarget_reg == $past(rawTarget))
		else $error("zero ramp time did not jump");

	chk_tick_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		tickCnt_reg < 32'(TICK_CYCLES))
		else $error("tick counter out of range");

	chk_freq_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tick |=> $stable(freqRef_reg))
		else $error("output moved off tick");

	chk_integ_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tick |=> $stable(integ_reg))
		else $error("integral moved off tick");

	chk_state_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tick |=> $stable(state_reg))
		else $error("state moved off tick");

	chk_dprev_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tick |=> $stable(dPrev_reg))
		else $error("derivative history moved off tick");

	chk_alarm_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
		!clkEn |=> $stable(settingConflictAlarm_reg))
		else $error("alarm moved while frozen");

	chk_display_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
		!clkEn |=> $stable(targetDisplay_reg))
		else $error("display moved while frozen");

	// ----------------------------------------
	// checks on source selection
	// ----------------------------------------
	chk_reserved_src: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cfg.targetSrc == 3'h3 || cfg.targetSrc == 3'h5 || cfg.targetSrc == 3'h7) |-> rawTarget == 16'h0000)
		else $error("reserved target source not zero");

	chk_main_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.targetSrc == `SRC_MAIN_CMD |-> rawTarget == mainFreqCmd)
		else $error("main command not picked as target");

	chk_stored_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.targetSrc == `SRC_STORED |-> rawTarget <= `PCT_FULL)
		else $error("stored target beyond full scale");

	chk_pump_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.targetSrc == `SRC_KEYPAD && !pumpAllowed |-> rawTarget == 16'h0000)
		else $error("pump target used without pump function");

	chk_pump_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.targetSrc == `SRC_KEYPAD && pumpAllowed |-> rawTarget == pumpTarget)
		else $error("pump target not picked");

	chk_fb_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.feedbackSrc == 2'h3 |-> feedback == 16'h0000)
		else $error("reserved feedback source not zero");

	chk_fb_none: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.feedbackSrc == 2'h0 |-> feedback == 16'h0000)
		else $error("unused feedback code not zero");

endmodule // pid_process_controller

// ===== feedback_transducer.sv
`timescale 1ns/1ps

// ----------------------------------------
// process transducer on both analog inputs
// ----------------------------------------
module feedback_transducer
(
	input  wire logic        core_clk,
	input  wire logic [15:0] levelOne,
	input  wire logic [15:0] levelTwo,
	output logic      [15:0] outOne,
	output logic      [15:0] outTwo
);
	// converter output saturates at its full span
	always_ff @(posedge core_clk)
	begin
		outOne <= (levelOne > 16'h0FFF) ? 16'h0FFF : levelOne;
		outTwo <= (levelTwo > 16'h0FFF) ? 16'h0FFF : levelTwo;
	end
endmodule // feedback_transducer

// ===== pid_process_controller_test.sv
`timescale 1ns/1ps

module pid_process_controller_test
	import pid_process_controller_pkg::*;
;
	logic               core_clk = 1'b0;
	logic               rst_n;
	logic               clkEn;
	pid_cfg_s           cfg;
	pid_cfg_s           base;
	pid_cfg_s           c;
	logic        [15:0] levelOne;
	logic        [15:0] levelTwo;
	logic        [15:0] analogInputOne;
	logic        [15:0] analogInputTwo;
	logic        [15:0] mainFreqCmd;
	logic        [15:0] pumpTarget;
	logic               driveRunning;
	logic signed [15:0] freqRef;
	logic        [15:0] targetDisplay;
	logic               alarm;
	logic               active;
	int                 fails = 0;
	int                 checked = 0;

	always #5 core_clk = ~core_clk;

	pid_process_controller #(.TICK_CYCLES(4)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .cfg(cfg),
		.analogInputOne(analogInputOne), .analogInputTwo(analogInputTwo),
		.mainFreqCmd(mainFreqCmd), .pumpTarget(pumpTarget), .driveRunning(driveRunning),
		.freqRef_reg(freqRef), .targetDisplay_reg(targetDisplay),
		.settingConflictAlarm_reg(alarm), .pidActive_reg(active));

	feedback_transducer fb_u (
		.core_clk(core_clk), .levelOne(levelOne), .levelTwo(levelTwo),
		.outOne(analogInputOne), .outTwo(analogInputTwo));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic signed [15:0] exp, input logic signed [15:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	// ten sample ticks let the output settle
	task automatic apply(input pid_cfg_s n);
		@(posedge core_clk);
		cfg <= n;
		repeat (40) @(posedge core_clk);
		#1;
	endtask

	task automatic expect_ref(input pid_cfg_s n, input logic signed [15:0] exp);
		apply(n);
		check("freqRef", exp, freqRef);
	endtask

	task automatic complete_run;
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#100000;
		fails++;
		complete_run;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		base = '{targetSrc: 3'h4, feedbackSrc: 2'h2, mode: 4'h1, storedTarget: 16'h01F4, propGain: 16'h0064,
			integTime: 16'h0000, diffTime: 16'h0000, allowReverse: 1'b0, rampTime: 16'h0000,
			integLimit: 16'h03E8, outLimit: 16'h03E8, bias: 16'h0000, outGain: 16'h000A,
			fbMax: 16'h0320, decimals: 2'h1, appFunction: 2'h0, ledModeZero: 1'b0};
		rst_n = 1'b0;
		clkEn = 1'b1;
		cfg = base;
		levelOne = 16'h0000;
		levelTwo = 16'h0000;
		mainFreqCmd = 16'h0000;
		pumpTarget = 16'h00FA;
		driveRunning = 1'b0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		expect_ref(base, 16'sd500);
		check("pidActive", 16'h0001, {15'h0000, active});
		check("targetDisplay", 16'h0190, targetDisplay);
		c = base; c.outLimit = 16'h012C;
		expect_ref(c, 16'sd300);
		c.bias = 16'h0032; c.outGain = 16'h0014;
		expect_ref(c, 16'sd400);
		c = base; c.mode = 4'h9;
		@(posedge core_clk);
		driveRunning <= 1'b1;
		mainFreqCmd <= 16'h00C8;
		expect_ref(c, 16'sd700);
		c.mode = 4'h3;
		expect_ref(c, 16'sd0);
		c.allowReverse = 1'b1;
		expect_ref(c, -16'sd500);
		c = base; c.targetSrc = 3'h1;
		@(posedge core_clk);
		levelOne <= 16'h0FFF;
		mainFreqCmd <= 16'h012C;
		expect_ref(c, 16'sd1000);
		c.targetSrc = 3'h6;
		expect_ref(c, 16'sd300);
		c.targetSrc = 3'h3;
		expect_ref(c, 16'sd0);
		c.targetSrc = 3'h0;
		expect_ref(c, 16'sd0);
		c.appFunction = 2'h1;
		expect_ref(c, 16'sd250);
		c.appFunction = 2'h2;
		expect_ref(c, 16'sd250);
		c = base; c.feedbackSrc = 2'h1;
		expect_ref(c, 16'sd0);
		c.feedbackSrc = 2'h3;
		expect_ref(c, 16'sd500);
		c = base; c.targetSrc = 3'h2;
		expect_ref(c, 16'sd0);
		check("alarm", 16'h0001, {15'h0000, alarm});
		check("pidActive", 16'h0000, {15'h0000, active});
		c = base; c.ledModeZero = 1'b1; c.fbMax = 16'h03E8;
		apply(c);
		check("alarm", 16'h0001, {15'h0000, alarm});
		c.fbMax = 16'h03E7;
		apply(c);
		check("alarm", 16'h0000, {15'h0000, alarm});
		c.decimals = 2'h2;
		apply(c);
		check("alarm", 16'h0001, {15'h0000, alarm});
		c = base; c.mode = 4'h0;
		expect_ref(c, 16'sd0);
		check("pidActive", 16'h0000, {15'h0000, active});
		expect_ref(base, 16'sd500);
		// a held clock enable must freeze the loop
		@(posedge core_clk);
		clkEn <= 1'b0;
		c = base; c.storedTarget = 16'h00C8;
		expect_ref(c, 16'sd500);
		@(posedge core_clk);
		clkEn <= 1'b1;
		expect_ref(c, 16'sd200);
		// a ramp of 0.1 s moves ten tenths per tick, so 200 to 500 is still under way
		c = base; c.rampTime = 16'h0001;
		apply(c);
		check("rampMoving", 16'h0001, {15'h0000, (freqRef > 16'sd200 && freqRef < 16'sd500)});
		// integral alone: 5 per tick, held at the limit of 20
		c = base; c.propGain = 16'h0000; c.integTime = 16'h000A; c.integLimit = 16'h0014;
		expect_ref(c, 16'sd20);
		complete_run;
	end
endmodule // pid_process_controller_test
